// ---- include/ahp_pkg.sv ----
// Shared constants and types for the byte-wide ADC host port.
// Assumes a 10 MHz aclk and an AXI4-Lite master for the side registers.
package ahp_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 100;
    // Internal conversion oscillator half period; one falling edge per six aclk cycles
    localparam int INT_OSC_PERIOD_NS = 250;
    // Least time, so round up; never below one cycle
    localparam int INT_OSC_CYCLES_RAW = (INT_OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INT_OSC_CYCLES = (INT_OSC_CYCLES_RAW < 1) ? 1 : INT_OSC_CYCLES_RAW;
    localparam logic [3:0] INT_OSC_LAST = 4'(INT_OSC_CYCLES - 1);
    // Falling conversion-clock edges from the write to the hold
    localparam logic [3:0] ACQ_HOLD_EDGE = 4'h4;
    // Falling conversion-clock edges spent in conversion, one per bit
    localparam logic [3:0] CONV_EDGES = 4'ha;

    // ==========================================================
    // Widths and fields
    // ==========================================================
    localparam int RES_W = 10;
    localparam int BUS_W = 8;
    localparam int CFG_ACQ_EXT_BIT = 5;
    localparam int HI_BITS = 2;
    localparam int LO_BITS = 8;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RESULT = 4'h8;
    localparam logic [3:0] REG_CONFIG = 4'hc;
    localparam int CTRL_INT_CLK_BIT = 0;
    localparam logic CTRL_INT_CLK_RST = 1'b1;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [9:0] RESULT_RST = 10'h000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACQ_INT,
        ST_ACQ_EXT,
        ST_CONV
    } ahp_state_t;

    // Host-side control pins, all active low except the byte select and the conversion clock
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic high_byte_select;
        logic conv_clk;
    } ahp_pins_t;

    // Pin levels while the host is idle
    localparam ahp_pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                        high_byte_select: 1'b0, conv_clk: 1'b0};

endpackage : ahp_pkg

// ---- logic/ahp_sync.sv ----
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes the receiving logic reads only the q output.
`timescale 1ns/1ps
`default_nettype none

module ahp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Data
    input wire logic [W-1:0] d,
    output var logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // ==========================================================
    // Two flops; the first is seen by the second only
    // ==========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule : ahp_sync

`default_nettype wire

// ---- logic/ahp_host_port.sv ----
// Byte-wide parallel host port of a 10-bit SAR converter, with its
// acquisition/conversion sequencer and an AXI4-Lite side register file.
// Assumes the host pins are asynchronous to aclk and the analog front end
// presents its code on sample_code in the aclk domain.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - high_byte_select high puts top two result bits out, low the eight lower.
// - The two lowest data lines carry bits 1:0, or 9:8 when selecting high.
// - conversion_done_n falls when a conversion ends and the result is ready.
// - Read strobe falling with chip select low drives the chosen byte out.
// - Internal acquisition: write rising latches config and starts acquire plus convert.
// - External acquisition: second write rising ends acquisition, starts conversion.
// - Chip select high keeps all eight data outputs released.
// - Tracking begins on a rising write strobe.
// - Internal acquisition holds on fourth falling clock edge after the config write.
// - Read strobe falling returns conversion_done_n high.
module ahp_host_port (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Host pins
    input wire ahp_pkg::ahp_pins_t pins,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    output logic conversion_done_n,
    // Analog front end
    input wire logic [9:0] sample_code,
    output logic tracking
);

    // ==========================================================
    // Declarations
    // ==========================================================
    ahp_pkg::ahp_pins_t pins_s;
    ahp_pkg::ahp_pins_t pins_d_r;
    logic [7:0] data_s;
    logic cs_act;
    logic rd_fall;
    logic wr_rise;
    logic ext_fall;
    logic int_fall;
    logic conv_fall;
    logic [3:0] osc_cnt_r;
    logic int_clk_r;
    logic [3:0] edge_cnt_r;
    ahp_pkg::ahp_state_t state_r;
    logic [7:0] config_r;
    logic [9:0] held_r;
    logic [9:0] result_r;
    logic reading_r;
    logic done_r;
    logic wr_cfg_acq_ext;
    // Register file
    logic ctrl_int_clk_r;
    logic aw_full_r;
    logic w_full_r;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic do_write;
    logic [31:0] rd_word;
    logic rd_ok;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    ahp_sync #(
        .W($bits(ahp_pkg::ahp_pins_t)),
        .RST_VAL(ahp_pkg::PINS_IDLE)
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(pins),
        .q(pins_s)
    );

    // Data in the same latency as the strobes, so a write edge sees it
    ahp_sync #(
        .W(ahp_pkg::BUS_W),
        .RST_VAL(8'h00)
    ) u_data_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(data_in),
        .q(data_s)
    );

    // History of synchronised pins for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_d_r <= ahp_pkg::PINS_IDLE;
        end else begin
            pins_d_r <= pins_s;
        end
    end

    // Edges qualified by chip select; strobes without it do nothing
    assign cs_act = !pins_s.cs_n;
    assign rd_fall = cs_act && pins_d_r.rd_n && !pins_s.rd_n;
    assign wr_rise = cs_act && !pins_d_r.wr_n && pins_s.wr_n;
    assign wr_cfg_acq_ext = data_s[ahp_pkg::CFG_ACQ_EXT_BIT];

    // ==========================================================
    // Conversion clock: pin or internal oscillator
    // ==========================================================
    // Internal oscillator as an enable; falling edge once per period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_cnt_r <= 4'h0;
            int_clk_r <= 1'b0;
        end else if (osc_cnt_r == ahp_pkg::INT_OSC_LAST) begin
            osc_cnt_r <= 4'h0;
            int_clk_r <= !int_clk_r;
        end else begin
            osc_cnt_r <= osc_cnt_r + 4'h1;
        end
    end

    assign int_fall = (osc_cnt_r == ahp_pkg::INT_OSC_LAST) && int_clk_r;
    // Pin clock only counts when the host runs it; a static pin gives no edges
    assign ext_fall = pins_d_r.conv_clk && !pins_s.conv_clk;
    assign conv_fall = ctrl_int_clk_r ? int_fall : ext_fall;

    // ==========================================================
    // Acquisition and conversion sequencer
    // ==========================================================
    // A write during conversion is ignored rather than restarting it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ahp_pkg::ST_IDLE;
            edge_cnt_r <= 4'h0;
            config_r <= ahp_pkg::CONFIG_RST;
            held_r <= ahp_pkg::RESULT_RST;
            tracking <= 1'b0;
        end else begin
            unique case (state_r)
                ahp_pkg::ST_IDLE,
                ahp_pkg::ST_ACQ_INT: begin
                    if (wr_rise) begin
                        config_r <= data_s;
                        tracking <= 1'b1;
                        edge_cnt_r <= 4'h0;
                        state_r <= wr_cfg_acq_ext ? ahp_pkg::ST_ACQ_EXT : ahp_pkg::ST_ACQ_INT;
                    end else if (state_r == ahp_pkg::ST_ACQ_INT && conv_fall) begin
                        if (edge_cnt_r == ahp_pkg::ACQ_HOLD_EDGE - 4'h1) begin
                            held_r <= sample_code;
                            tracking <= 1'b0;
                            edge_cnt_r <= 4'h0;
                            state_r <= ahp_pkg::ST_CONV;
                        end else begin
                            edge_cnt_r <= edge_cnt_r + 4'h1;
                        end
                    end
                end
                ahp_pkg::ST_ACQ_EXT: begin
                    // Next write ends tracking; config stays as written
                    if (wr_rise) begin
                        held_r <= sample_code;
                        tracking <= 1'b0;
                        edge_cnt_r <= 4'h0;
                        state_r <= ahp_pkg::ST_CONV;
                    end
                end
                ahp_pkg::ST_CONV: begin
                    if (conv_fall) begin
                        if (edge_cnt_r == ahp_pkg::CONV_EDGES - 4'h1) begin
                            state_r <= ahp_pkg::ST_IDLE;
                            edge_cnt_r <= 4'h0;
                        end else begin
                            edge_cnt_r <= edge_cnt_r + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Result update at the last conversion edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_r <= ahp_pkg::RESULT_RST;
        end else if (state_r == ahp_pkg::ST_CONV && conv_fall && edge_cnt_r == ahp_pkg::CONV_EDGES - 4'h1) begin
            result_r <= held_r;
        end
    end

    // Done flag: a finishing conversion wins over a read in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_r <= 1'b0;
        end else if (state_r == ahp_pkg::ST_CONV && conv_fall && edge_cnt_r == ahp_pkg::CONV_EDGES - 4'h1) begin
            done_r <= 1'b1;
        end else if (rd_fall) begin
            done_r <= 1'b0;
        end
    end

    assign conversion_done_n = !done_r;

    // ==========================================================
    // Data bus drive
    // ==========================================================
    // Read window opens on a qualified read fall, closes on rd or cs rise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reading_r <= 1'b0;
        end else if (rd_fall) begin
            reading_r <= 1'b1;
        end else if (pins_s.rd_n || pins_s.cs_n) begin
            reading_r <= 1'b0;
        end
    end

    // Byte mux registered; high byte sits on the two lowest lines
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_out <= 8'h00;
        end else if (pins_s.high_byte_select) begin
            data_out <= {6'h00, result_r[ahp_pkg::RES_W-1 -: ahp_pkg::HI_BITS]};
        end else begin
            data_out <= result_r[ahp_pkg::LO_BITS-1:0];
        end
    end

    // Released on synchronised chip select; two flops of lag, never raw pin logic
    assign data_oe_n = !(reading_r && !pins_s.cs_n);

    // ==========================================================
    // AXI4-Lite write channel
    // ==========================================================
    assign s_axi_awready = !aw_full_r;
    assign s_axi_wready = !w_full_r;
    assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;

    // Address and data are held independently, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (do_write) begin
                w_full_r <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ahp_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_r == ahp_pkg::REG_CTRL || aw_addr_r == ahp_pkg::REG_STATUS ||
                            aw_addr_r == ahp_pkg::REG_RESULT || aw_addr_r == ahp_pkg::REG_CONFIG)
                           ? ahp_pkg::RESP_OKAY : ahp_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register: only the clock-source bit is writable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_int_clk_r <= ahp_pkg::CTRL_INT_CLK_RST;
        end else if (do_write && aw_addr_r == ahp_pkg::REG_CTRL && w_strb_r[0]) begin
            ctrl_int_clk_r <= w_data_r[ahp_pkg::CTRL_INT_CLK_BIT];
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    // ==========================================================
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            ahp_pkg::REG_CTRL: rd_word[ahp_pkg::CTRL_INT_CLK_BIT] = ctrl_int_clk_r;
            ahp_pkg::REG_STATUS: rd_word[5:0] = {tracking, reading_r, state_r, conversion_done_n, done_r};
            ahp_pkg::REG_RESULT: rd_word[ahp_pkg::RES_W-1:0] = result_r;
            ahp_pkg::REG_CONFIG: rd_word[7:0] = config_r;
            default: rd_ok = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    // One read in flight; data registered with the valid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ahp_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? ahp_pkg::RESP_OKAY : ahp_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : ahp_host_port

`default_nettype wire

// ---- sim/ahp_host_port_props.sv ----
// Concurrent checks on the host-pin side of the ADC host port.
// Assumes it is bound into ahp_host_port; pins arrive raw, two flops ahead of the logic.
`timescale 1ns/1ps
`default_nettype none

module ahp_host_port_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Host pins
    input wire ahp_pkg::ahp_pins_t pins,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n,
    input wire logic conversion_done_n,
    // Analog side
    input wire logic tracking
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic ext_acq_r;
    logic conv_r;

    // ==========================================================
    // Helper state
    // ==========================================================
    // Mode of the last accepted config
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_acq_r <= 1'b0;
        end else if ($rose(pins.wr_n) && !pins.cs_n && !tracking && !conv_r) begin
            ext_acq_r <= data_in[ahp_pkg::CFG_ACQ_EXT_BIT];
        end
    end

    // Conversion in flight, from hold until the done line falls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_r <= 1'b0;
        end else if ($fell(tracking)) begin
            conv_r <= 1'b1;
        end else if ($fell(conversion_done_n)) begin
            conv_r <= 1'b0;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    // Chip select passes two flops, so the release lags the pin by that much
    a_cs_release: assert property (
        pins.cs_n [*3] |-> data_oe_n) else $error("data bus driven while deselected");
    a_read_drives: assert property (
        $fell(pins.rd_n) && !pins.cs_n |-> ##[2:6] !data_oe_n) else $error("read did not drive bus");
    a_drive_cause: assert property (
        $fell(data_oe_n) |-> !pins.rd_n && !$past(pins.rd_n, 2)) else $error("bus driven without read");
    a_done_clear: assert property (
        $fell(pins.rd_n) && !pins.cs_n && !conversion_done_n |-> ##[2:6] conversion_done_n)
        else $error("read did not clear done");
    a_high_upper: assert property (
        (!data_oe_n && pins.high_byte_select) [*4] |-> data_out[7:2] == 6'h00)
        else $error("upper lines not zero on high byte");
    a_cs_ignore: assert property (
        pins.cs_n [*6] |-> !$rose(tracking)) else $error("strobe acted while deselected");
    a_track_start: assert property (
        $rose(pins.wr_n) && !pins.cs_n && !tracking && !conv_r |-> ##[2:6] tracking)
        else $error("write did not start tracking");
    a_ext_end: assert property (
        $rose(pins.wr_n) && !pins.cs_n && tracking && ext_acq_r |-> ##[2:6] !tracking)
        else $error("write did not end acquisition");
    a_int_hold: assert property (
        $rose(tracking) && !ext_acq_r |-> tracking [*8] ##[6:20] $fell(tracking))
        else $error("hold not on fourth clock fall");
    a_conv_len: assert property (
        $fell(tracking) && conversion_done_n |-> ##[52:72] $fell(conversion_done_n))
        else $error("done not after ten clock falls");
endmodule : ahp_host_port_props

bind ahp_host_port ahp_host_port_props u_props (
    .aclk(aclk), .aresetn(aresetn), .pins(pins), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .conversion_done_n(conversion_done_n), .tracking(tracking)
);
`default_nettype wire

// ---- sim/ahp_host_model.sv ----
// Host model on the byte-wide bus: strobes, config writes, byte reads, pin clock.
// Assumes the bench calls its tasks just after a rising aclk edge, one at a time.
`timescale 1ns/1ps
`default_nettype none

module ahp_host_model (
    // Clock
    input wire logic aclk,
    // Pins toward the device
    output var ahp_pkg::ahp_pins_t pins,
    output logic [7:0] data_in,
    // Device bus side
    input wire logic [7:0] data_out,
    input wire logic data_oe_n
);
    logic ext_clk_en = 1'b0;
    logic drv_en = 1'b0;
    logic [7:0] drv = 8'h00;
    logic [7:0] last = 8'h00;
    logic [1:0] div = 2'h0;

    initial pins = ahp_pkg::PINS_IDLE;

    // Bus level: released bus shows a toggling pattern so stale data never looks valid
    assign data_in = drv_en ? drv : (!data_oe_n ? data_out : ~last);

    // Pin clock of six aclk when enabled, held at its last level otherwise
    always @(posedge aclk) begin
        last <= data_in;
        if (ext_clk_en) begin
            div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
            if (div == 2'h2) pins.conv_clk <= ~pins.conv_clk;
        end
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_clk

    // Write strobe; data released before any read
    task automatic strobe(input logic cs_lvl, input logic drive, input logic [7:0] cfg);
        @(posedge aclk);
        pins.cs_n <= cs_lvl;
        drv <= cfg;
        drv_en <= drive;
        wait_clk(4);
        pins.wr_n <= 1'b0;
        wait_clk(4);
        pins.wr_n <= 1'b1;
        wait_clk(4);
        pins.cs_n <= 1'b1;
        drv_en <= 1'b0;
        wait_clk(8);
    endtask : strobe

    // Byte read; select settles before the strobe
    task automatic read_byte(input logic cs_lvl, input logic hbs, output logic [7:0] b, output logic oe_n);
        @(posedge aclk);
        pins.cs_n <= cs_lvl;
        pins.high_byte_select <= hbs;
        wait_clk(4);
        pins.rd_n <= 1'b0;
        wait_clk(8);
        b = data_in;
        oe_n = data_oe_n;
        pins.rd_n <= 1'b1;
        wait_clk(4);
        pins.cs_n <= 1'b1;
        wait_clk(4);
    endtask : read_byte
endmodule : ahp_host_model
`default_nettype wire

// ---- sim/test_adc_parallel_host_port.sv ----
// Self-checking bench: host pins through the host model, registers over AXI4-Lite.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none

module test_adc_parallel_host_port;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, data_oe_n, conversion_done_n, tracking, oe;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] data_in, data_out, b;
    logic [9:0] sample_code;
    ahp_pkg::ahp_pins_t pins;
    int fails, tests_run;

    ahp_host_port DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pins(pins),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .conversion_done_n(conversion_done_n),
        .sample_code(sample_code), .tracking(tracking));
    ahp_host_model u_host (.aclk(aclk), .pins(pins), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic check(input string what, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // Ready lines are high from reset and drop while a beat is held; all changes follow a rising edge
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : axi_rd

    // Bounded wait: sel 0 tracking, sel 1 done line
    task automatic wait_sig(input logic sel, input logic lvl, input string what);
        int n = 0;
        @(negedge aclk);
        while ((sel ? conversion_done_n : tracking) !== lvl && n < 100) begin
            @(negedge aclk);
            n++;
        end
        check(what, lvl, sel ? conversion_done_n : tracking);
        @(posedge aclk);
    endtask : wait_sig

    task automatic t_reset;
        check("oe_n", 1'b1, data_oe_n);
        check("done_n", 1'b1, conversion_done_n);
        check("tracking", 1'b0, tracking);
        axi_rd(ahp_pkg::REG_CTRL, d, r);
        check("ctrl reset", 32'h1, d);
    endtask : t_reset

    task automatic t_ignore;
        u_host.strobe(1'b1, 1'b1, 8'h00);
        u_host.read_byte(1'b1, 1'b0, b, oe);
        check("oe_n deselected", 1'b1, oe);
        check("tracking deselected", 1'b0, tracking);
        axi_rd(ahp_pkg::REG_STATUS, d, r);
        check("state deselected", 2'h0, d[3:2]);
    endtask : t_ignore

    task automatic t_int;
        sample_code <= 10'h2a5;
        u_host.strobe(1'b0, 1'b1, 8'h00);
        wait_sig(1'b0, 1'b1, "tracking on");
        wait_sig(1'b0, 1'b0, "hold internal");
        wait_sig(1'b1, 1'b0, "done internal");
        axi_rd(ahp_pkg::REG_RESULT, d, r);
        check("result internal", 32'h2a5, d);
        u_host.read_byte(1'b0, 1'b0, b, oe);
        check("low byte", 8'ha5, b);
        check("oe_n read", 1'b0, oe);
        check("done_n after read", 1'b1, conversion_done_n);
        u_host.read_byte(1'b0, 1'b1, b, oe);
        check("high byte", 8'h02, b);
    endtask : t_int

    task automatic t_ext;
        axi_wr(ahp_pkg::REG_CTRL, 32'h0, r);
        check("ctrl resp", ahp_pkg::RESP_OKAY, r);
        u_host.ext_clk_en = 1'b1;
        sample_code <= 10'h15a;
        u_host.strobe(1'b0, 1'b1, 8'h20);
        wait_sig(1'b0, 1'b1, "tracking ext");
        repeat (40) @(posedge aclk);
        check("tracking held", 1'b1, tracking);
        sample_code <= 10'h1c3;
        u_host.strobe(1'b0, 1'b0, 8'h00);
        wait_sig(1'b0, 1'b0, "hold external");
        wait_sig(1'b1, 1'b0, "done external");
        u_host.ext_clk_en = 1'b0;
        axi_rd(ahp_pkg::REG_CONFIG, d, r);
        check("config kept", 32'h20, d);
        u_host.read_byte(1'b0, 1'b1, b, oe);
        check("high byte ext", 8'h01, b);
        u_host.read_byte(1'b0, 1'b0, b, oe);
        check("low byte ext", 8'hc3, b);
    endtask : t_ext

    task automatic t_unmapped;
        axi_wr(4'h2, 32'h1, r);
        check("unmapped write", ahp_pkg::RESP_SLVERR, r);
        axi_rd(4'h2, d, r);
        check("unmapped read", ahp_pkg::RESP_SLVERR, r);
        axi_wr(ahp_pkg::REG_RESULT, 32'h3ff, r);
        axi_rd(ahp_pkg::REG_RESULT, d, r);
        check("result read-only", 32'h1c3, d);
        axi_rd(ahp_pkg::REG_CTRL, d, r);
        check("ctrl untouched", 32'h0, d);
    endtask : t_unmapped

    // Run is near 400 cycles; ample margin
    initial begin
        repeat (8000) @(posedge aclk);
        fails++;
        $display("mismatch watchdog expected finish seen hang");
        complete_run;
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h05;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sample_code} = '0;
        s_axi_wstrb = 4'hf;
        fails = 0;
        tests_run = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        t_reset;
        t_ignore;
        t_int;
        t_ext;
        t_unmapped;
        complete_run;
    end
endmodule : test_adc_parallel_host_port
`default_nettype wire
